// ### design/asr_pkg.sv
// Package of constants and types for the status and sample register bank
// ============================================================
// Functional notes
// - Upset flag bit 7 set at power-up and soft reset, cleared by any write
// - Upset flag also set when a register upset or glitch is reported
// - Bit 6 shows motion state, 1 active, 0 inactive, reset value 1
// - Outside linked or loop mode motion state stays 1; host ignores it
// - Bit 5 set when inactivity or free fall is detected
// - Bit 4 set when activity above threshold is detected
// - Bit 3 set when the sample queue overruns unread entries
// - Bit 2 high while queue holds at least the watermark count
// - Bit 1 high while at least one sample waits in the queue
// - Bit 0 set on new valid sample, cleared on a queue read
// - Status byte is read-only and resets to 0x40
// - Queue count 0..512 as 10 bits split over low and high registers
// - Each axis gives a 12-bit signed result in a low/high register pair
// - High result bits 15..12 repeat result bit 11
// - Temperature uses the same sign-extended 12-bit pair format
// - Writing 0x52 to the reset register resets status, sample results and pin enables to defaults
// - Soft reset puts interrupt pins in high impedance, level held
// - Reset register is write-only and reads back 0x00
// - Sequencing field: X0 default, 01 linked, 11 loop
// - Default/linked events acked by status read; loop acks internally
package asr_pkg;

  // ============================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS_FLAGS   = 8'h0b;
  localparam logic [7:0] OFS_QCOUNT_LOW     = 8'h0c;
  localparam logic [7:0] OFS_QCOUNT_HIGH    = 8'h0d;
  localparam logic [7:0] OFS_X_ACCEL_LOW    = 8'h0e;
  localparam logic [7:0] OFS_X_ACCEL_HIGH   = 8'h0f;
  localparam logic [7:0] OFS_Y_ACCEL_LOW    = 8'h10;
  localparam logic [7:0] OFS_Y_ACCEL_HIGH   = 8'h11;
  localparam logic [7:0] OFS_Z_ACCEL_LOW    = 8'h12;
  localparam logic [7:0] OFS_Z_ACCEL_HIGH   = 8'h13;
  localparam logic [7:0] OFS_THERMAL_LOW    = 8'h14;
  localparam logic [7:0] OFS_THERMAL_HIGH   = 8'h15;
  localparam logic [7:0] OFS_SW_RESET_TRIG  = 8'h1f;

  // ============================================================
  // Values
  localparam logic [7:0] STATUS_RESET_VAL   = 8'h40;
  localparam logic [7:0] SW_RESET_CODE      = 8'h52;
  localparam logic [7:0] READ_ZERO          = 8'h00;
  localparam logic [11:0] SAMPLE_RESET_VAL  = 12'h000;
  localparam int          RESULT_WIDTH      = 12;
  localparam int          QCOUNT_WIDTH      = 10;

  // Host settle time after soft reset, in microseconds
  localparam int SW_RESET_SETTLE_US = 500;
  localparam int CLK_MHZ            = 100;
  localparam int SW_RESET_SETTLE_CYC = SW_RESET_SETTLE_US * CLK_MHZ;

  // ============================================================
  // Types
  typedef enum logic [1:0] {
    SEQ_DEFAULT     = 2'b00,
    SEQ_LINKED      = 2'b01,
    SEQ_DEFAULT_ALT = 2'b10,
    SEQ_LOOP        = 2'b11
  } asr_seq_e;

  typedef struct packed {
    logic configUpset;
    logic awake;
    logic stillnessFlag;
    logic motionFlag;
    logic queueOverrun;
    logic queueWatermark;
    logic queueReady;
    logic dataReady;
  } asr_status_s;

  typedef struct packed {
    logic [11:0] xAccel;
    logic [11:0] yAccel;
    logic [11:0] zAccel;
    logic [11:0] thermal;
  } asr_sample_s;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } asr_reg_req_s;

endpackage : asr_pkg

// ### design/asr_status_sample_regs.sv
// Status, queue count, sample result and soft reset register bank
`timescale 1ns/1ps
`default_nettype none
module asr_status_sample_regs
  import asr_pkg::*;
#(
  parameter int QCOUNT_W = QCOUNT_WIDTH
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Register access from the serial interface
  input  wire asr_reg_req_s      regReq,
  output logic [7:0]             regRdData,
  output logic                   regRdValid,
  // Motion and queue engine
  input  wire asr_seq_e          seqMode,
  input  wire logic              activityEvt,
  input  wire logic              inactivityEvt,
  input  wire logic              upsetEvt,
  input  wire logic              sampleStrobe,
  input  wire asr_sample_s       sampleIn,
  input  wire logic [QCOUNT_W-1:0] queueCount,
  input  wire logic [QCOUNT_W-1:0] watermarkLevel,
  input  wire logic              queueOverrunEvt,
  input  wire logic              queueReadEvt,
  // Interrupt pins from the mapper
  input  wire logic              int1Req,
  input  wire logic              int2Req,
  output logic                   int1Out,
  output logic                   int1OeN,
  output logic                   int2Out,
  output logic                   int2OeN,
  // Soft reset indication to the rest of the device
  output logic                   softResetPulse
);

  // ============================================================
  // Helpers
  function automatic logic [7:0] highByte(input logic [11:0] v);
    highByte = {{4{v[11]}}, v[11:8]};
  endfunction : highByte

  // ============================================================
  // State
  asr_status_s status_ff;
  asr_sample_s sample_ff;
  logic        pwrUp_ff;
  logic        pinsHiZ_ff;
  logic [7:0]  rdData_ff;
  logic        rdValid_ff;
  logic        softRst_ff;
  logic        int1_ff;
  logic        int2_ff;

  // ============================================================
  // Decode
  wire logic swResetHit = regReq.wrEn &&
                          regReq.addr == OFS_SW_RESET_TRIG &&
                          regReq.wrData == SW_RESET_CODE;
  wire logic statusRead = regReq.rdEn && regReq.addr == OFS_STATUS_FLAGS;
  wire logic seqLinked  = seqMode == SEQ_LINKED;
  wire logic seqLoop    = seqMode == SEQ_LOOP;
  wire logic seqAuto    = seqLinked || seqLoop;
  // Loop mode acknowledges internally, so status reads leave flags alone
  wire logic hostAck    = statusRead && !seqLoop;

  wire logic [QCOUNT_W-1:0] qZero = '0;
  wire logic watermarkLvl = queueCount >= watermarkLevel;
  wire logic readyLvl     = queueCount != qZero;

  // ============================================================
  // Next status
  asr_status_s nxt_status;
  always_comb begin
    nxt_status = status_ff;
    // Any write counts as configuring; an upset in the same cycle wins
    if (regReq.wrEn) begin
      nxt_status.configUpset = 1'b0;
    end
    if (pwrUp_ff || upsetEvt) begin
      nxt_status.configUpset = 1'b1;
    end
    if (!seqAuto) begin
      nxt_status.awake = 1'b1;
    end else if (activityEvt) begin
      nxt_status.awake = 1'b1;
    end else if (inactivityEvt) begin
      nxt_status.awake = 1'b0;
    end
    if (hostAck) begin
      nxt_status.motionFlag    = 1'b0;
      nxt_status.stillnessFlag = 1'b0;
      nxt_status.queueOverrun  = 1'b0;
    end
    // Loop mode: each event retires the opposite one
    if (seqLoop && activityEvt) begin
      nxt_status.stillnessFlag = 1'b0;
    end
    if (seqLoop && inactivityEvt) begin
      nxt_status.motionFlag = 1'b0;
    end
    if (activityEvt) begin
      nxt_status.motionFlag = 1'b1;
    end
    if (inactivityEvt) begin
      nxt_status.stillnessFlag = 1'b1;
    end
    if (queueOverrunEvt) begin
      nxt_status.queueOverrun = 1'b1;
    end
    nxt_status.queueWatermark = watermarkLvl;
    nxt_status.queueReady     = readyLvl;
    if (queueReadEvt) begin
      nxt_status.dataReady = 1'b0;
    end
    if (sampleStrobe) begin
      nxt_status.dataReady = 1'b1;
    end
  end

  // ============================================================
  // Read mux; data written to read-only offsets is not stored
  logic [7:0] nxt_rdData;
  always_comb begin
    nxt_rdData = READ_ZERO;
    unique case (regReq.addr)
      OFS_STATUS_FLAGS:  nxt_rdData = status_ff;
      OFS_QCOUNT_LOW:    nxt_rdData = queueCount[7:0];
      OFS_QCOUNT_HIGH:   nxt_rdData = {6'h00, queueCount[9:8]};
      OFS_X_ACCEL_LOW:   nxt_rdData = sample_ff.xAccel[7:0];
      OFS_X_ACCEL_HIGH:  nxt_rdData = highByte(sample_ff.xAccel);
      OFS_Y_ACCEL_LOW:   nxt_rdData = sample_ff.yAccel[7:0];
      OFS_Y_ACCEL_HIGH:  nxt_rdData = highByte(sample_ff.yAccel);
      OFS_Z_ACCEL_LOW:   nxt_rdData = sample_ff.zAccel[7:0];
      OFS_Z_ACCEL_HIGH:  nxt_rdData = highByte(sample_ff.zAccel);
      OFS_THERMAL_LOW:   nxt_rdData = sample_ff.thermal[7:0];
      OFS_THERMAL_HIGH:  nxt_rdData = highByte(sample_ff.thermal);
      OFS_SW_RESET_TRIG: nxt_rdData = READ_ZERO;
      default:           nxt_rdData = READ_ZERO;
    endcase
  end

  // Pins stay released after soft reset until software configures again
  wire logic nxt_pinsHiZ = swResetHit ? 1'b1 :
                           (regReq.wrEn ? 1'b0 : pinsHiZ_ff);

  // ============================================================
  // Status and power-up marker
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= STATUS_RESET_VAL;
      pwrUp_ff  <= 1'b1;
    end else if (swResetHit) begin
      status_ff <= STATUS_RESET_VAL;
      pwrUp_ff  <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      pwrUp_ff  <= 1'b0;
    end
  end

  // ============================================================
  // Sample results
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sample_ff <= '0;
    end else if (swResetHit) begin
      sample_ff <= '0;
    end else if (sampleStrobe) begin
      sample_ff <= sampleIn;
    end
  end

  // ============================================================
  // Read port, soft reset and pins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff  <= READ_ZERO;
      rdValid_ff <= 1'b0;
      softRst_ff <= 1'b0;
      pinsHiZ_ff <= 1'b1;
      int1_ff    <= 1'b0;
      int2_ff    <= 1'b0;
    end else begin
      rdData_ff  <= regReq.rdEn ? nxt_rdData : READ_ZERO;
      rdValid_ff <= regReq.rdEn;
      softRst_ff <= swResetHit;
      pinsHiZ_ff <= nxt_pinsHiZ;
      // Keeper behaviour: last level holds while released
      if (!nxt_pinsHiZ) begin
        int1_ff <= int1Req;
        int2_ff <= int2Req;
      end
    end
  end

  assign regRdData      = rdData_ff;
  assign regRdValid     = rdValid_ff;
  assign softResetPulse = softRst_ff;
  assign int1Out        = int1_ff;
  assign int2Out        = int2_ff;
  assign int1OeN        = pinsHiZ_ff;
  assign int2OeN        = pinsHiZ_ff;

  // ============================================================
  // Checks
  a_upset_after_reset: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $past(swResetHit) && !swResetHit |=> status_ff.configUpset)
    else $error("upset flag not set after soft reset");

  a_upset_write_clear: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.wrEn && !swResetHit && !upsetEvt && !pwrUp_ff
    |=> !status_ff.configUpset)
    else $error("upset flag not cleared by write");

  a_upset_event_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    upsetEvt && !swResetHit |=> status_ff.configUpset)
    else $error("upset event lost");

  a_awake_default_one: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !seqAuto && !swResetHit |=> status_ff.awake)
    else $error("motion state not held in default mode");

  a_awake_goes_idle: assert property (
    @(posedge mclk) disable iff (!arst_n)
    seqAuto && inactivityEvt && !activityEvt && !swResetHit
    |=> !status_ff.awake)
    else $error("motion state not cleared on inactivity");

  a_motion_flag_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    activityEvt && !swResetHit |=> status_ff.motionFlag)
    else $error("activity flag not set");

  a_still_flag_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    inactivityEvt && !swResetHit |=> status_ff.stillnessFlag)
    else $error("inactivity flag not set");

  a_overrun_sticky: assert property (
    @(posedge mclk) disable iff (!arst_n)
    queueOverrunEvt && !swResetHit ##1 !hostAck && !swResetHit
    |=> status_ff.queueOverrun)
    else $error("overrun flag not sticky");

  a_watermark_level: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !swResetHit |=> status_ff.queueWatermark == $past(watermarkLvl))
    else $error("watermark flag wrong");

  a_ready_clear: assert property (
    @(posedge mclk) disable iff (!arst_n)
    queueReadEvt && !sampleStrobe |=> !status_ff.dataReady)
    else $error("data ready not cleared by queue read");

  a_high_sign_copy: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_X_ACCEL_HIGH
    |=> regRdData[7:4] == {4{$past(sample_ff.xAccel[11])}})
    else $error("sign copy bits wrong");

  a_reset_reads_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_SW_RESET_TRIG
    |=> regRdValid && regRdData == READ_ZERO)
    else $error("reset register read not zero");

  a_pins_released: assert property (
    @(posedge mclk) disable iff (!arst_n)
    swResetHit |=> int1OeN && int2OeN && softResetPulse)
    else $error("pins not released on soft reset");

  a_other_code_inert: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.wrEn && regReq.addr == OFS_SW_RESET_TRIG &&
    regReq.wrData != SW_RESET_CODE |=> !softResetPulse)
    else $error("non-code write caused reset");

  a_powerup_upset: assert property (
    @(posedge mclk) disable iff (!arst_n)
    pwrUp_ff && !swResetHit |=> status_ff.configUpset)
    else $error("upset flag not set after power-up");

  a_ready_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    sampleStrobe && !swResetHit |=> status_ff.dataReady)
    else $error("data ready not set by new sample");

  a_queue_ready: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !swResetHit |=> status_ff.queueReady == $past(readyLvl))
    else $error("queue ready flag wrong");

  a_still_ack: assert property (
    @(posedge mclk) disable iff (!arst_n)
    hostAck && !inactivityEvt && !swResetHit |=> !status_ff.stillnessFlag)
    else $error("inactivity flag not acknowledged by read");

  a_motion_ack: assert property (
    @(posedge mclk) disable iff (!arst_n)
    hostAck && !activityEvt && !swResetHit |=> !status_ff.motionFlag)
    else $error("activity flag not acknowledged by read");

  a_loop_no_ack: assert property (
    @(posedge mclk) disable iff (!arst_n)
    seqLoop && statusRead && status_ff.motionFlag && !inactivityEvt &&
    !swResetHit |=> status_ff.motionFlag)
    else $error("status read cleared flag in loop mode");

  a_loop_retire: assert property (
    @(posedge mclk) disable iff (!arst_n)
    seqLoop && activityEvt && !inactivityEvt && !swResetHit
    |=> !status_ff.stillnessFlag)
    else $error("loop mode did not retire inactivity flag");

  a_awake_wakes: assert property (
    @(posedge mclk) disable iff (!arst_n)
    seqAuto && activityEvt && !swResetHit |=> status_ff.awake)
    else $error("motion state not set on activity");

  a_status_read_data: assert property (
    @(posedge mclk) disable iff (!arst_n)
    statusRead |=> regRdValid && regRdData == $past(status_ff))
    else $error("status read data wrong");

  a_qcount_low: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_QCOUNT_LOW
    |=> regRdData == $past(queueCount[7:0]))
    else $error("queue count low byte wrong");

  a_qcount_high: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_QCOUNT_HIGH
    |=> regRdData == {6'h00, $past(queueCount[9:8])})
    else $error("queue count high byte wrong");

  a_y_sign_copy: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_Y_ACCEL_HIGH
    |=> regRdData[7:4] == {4{$past(sample_ff.yAccel[11])}})
    else $error("y sign copy bits wrong");

  a_z_sign_copy: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_Z_ACCEL_HIGH
    |=> regRdData[7:4] == {4{$past(sample_ff.zAccel[11])}})
    else $error("z sign copy bits wrong");

  a_thermal_sign_copy: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.rdEn && regReq.addr == OFS_THERMAL_HIGH
    |=> regRdData[7:4] == {4{$past(sample_ff.thermal[11])}})
    else $error("temperature sign copy bits wrong");

  a_sample_capture: assert property (
    @(posedge mclk) disable iff (!arst_n)
    sampleStrobe && !swResetHit |=> sample_ff == $past(sampleIn))
    else $error("sample not captured");

  a_soft_reset_state: assert property (
    @(posedge mclk) disable iff (!arst_n)
    swResetHit |=> status_ff == STATUS_RESET_VAL && sample_ff == '0)
    else $error("soft reset did not restore defaults");

  a_pulse_one_cycle: assert property (
    @(posedge mclk) disable iff (!arst_n)
    softResetPulse && !swResetHit |=> !softResetPulse)
    else $error("soft reset pulse too long");

  a_pins_redriven: assert property (
    @(posedge mclk) disable iff (!arst_n)
    regReq.wrEn && !swResetHit |=> !int1OeN && !int2OeN)
    else $error("pins not driven after write");

  a_pins_keep: assert property (
    @(posedge mclk) disable iff (!arst_n)
    int1OeN && !regReq.wrEn |=> $stable(int1Out) && $stable(int2Out))
    else $error("released pin level not held");

endmodule : asr_status_sample_regs
`default_nettype wire

// ### verif/asr_host_model.sv
// Host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module asr_host_model
  import asr_pkg::*;
(
  input  wire logic       mclk,
  output var asr_reg_req_s regReq,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  logic [7:0] rdVal;
  logic       rdOk;
  initial regReq = '0;
  // ============================================================
  // Bus cycles
  // Idle address and data inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge mclk);
    regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : wr
  // Status reads double as event acknowledge outside loop mode
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(negedge mclk);
    regReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: 8'hff};
    rdOk  = regRdValid;
    rdVal = regRdData;
  endtask : rd
  // No access while the device settles after a soft reset
  task automatic settle();
    repeat (SW_RESET_SETTLE_CYC) @(posedge mclk);
  endtask : settle
endmodule : asr_host_model
`default_nettype wire

// ### verif/tb_asr_status_sample_regs.sv
// Self-checking bench for the status and sample register bank
`timescale 1ns/1ps
`default_nettype none
module tb_asr_status_sample_regs;
  import asr_pkg::*;
  logic         mclk, arst_n, activityEvt, inactivityEvt, upsetEvt;
  logic         sampleStrobe, queueOverrunEvt, queueReadEvt;
  logic         int1Req, int2Req, int1Out, int1OeN, int2Out, int2OeN;
  logic         regRdValid, softResetPulse;
  logic [7:0]   regRdData;
  logic [9:0]   queueCount, watermarkLevel;
  logic [15:0]  lf;
  asr_seq_e     seqMode;
  asr_sample_s  sampleIn;
  asr_reg_req_s regReq;
  int           n_fail, compares, mStat, smp[4], qv[6];
  asr_seq_e     modes[4] = '{SEQ_DEFAULT, SEQ_DEFAULT_ALT, SEQ_LINKED, SEQ_LOOP};

  asr_status_sample_regs asr_status_sample_regs_i (.mclk, .arst_n, .regReq,
    .regRdData, .regRdValid, .seqMode, .activityEvt, .inactivityEvt,
    .upsetEvt, .sampleStrobe, .sampleIn, .queueCount, .watermarkLevel,
    .queueOverrunEvt, .queueReadEvt, .int1Req, .int2Req, .int1Out,
    .int1OeN, .int2Out, .int2OeN, .softResetPulse);
  asr_host_model host_i (.mclk, .regReq, .regRdData, .regRdValid);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ============================================================
  // Model and compare
  function automatic logic [15:0] nextLf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextLf
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input int e);
    host_i.rd(a);
    chk({7'h0, host_i.rdOk}, 8'h01);
    chk(host_i.rdVal, 8'(e));
  endtask : rdChk
  task automatic rdStat();
    int e;
    e = (mStat & 'hf9) | ((queueCount >= watermarkLevel) ? 4 : 0);
    e = e | ((queueCount != 0) ? 2 : 0);
    rdChk(OFS_STATUS_FLAGS, e);
    if (seqMode != SEQ_LOOP) mStat = mStat & 'hc7;
  endtask : rdStat
  task automatic rdSmp();
    for (int i = 0; i < 4; i++) begin
      rdChk(OFS_X_ACCEL_LOW + 8'(2 * i), smp[i] & 'hff);
      rdChk(OFS_X_ACCEL_HIGH + 8'(2 * i),
            (smp[i] >> 8) | ((smp[i] & 'h800) ? 'hf0 : 0));
    end
  endtask : rdSmp
  // Event pulse on the engine side with the expected flag update
  task automatic ev(input int k);
    @(negedge mclk);
    case (k)
      0: activityEvt = 1'b1;
      1: inactivityEvt = 1'b1;
      2: upsetEvt = 1'b1;
      3: queueOverrunEvt = 1'b1;
      4: sampleStrobe = 1'b1;
      default: queueReadEvt = 1'b1;
    endcase
    sampleIn = {12'(smp[0]), 12'(smp[1]), 12'(smp[2]), 12'(smp[3])};
    case (k)
      0: mStat = (mStat | 'h50) & ((seqMode == SEQ_LOOP) ? 'hdf : 'hff);
      1: mStat = (mStat | 'h20) & (seqMode[0] ? 'hbf : 'hff)
                 & ((seqMode == SEQ_LOOP) ? 'hef : 'hff);
      2: mStat = mStat | 'h80;
      3: mStat = mStat | 'h08;
      4: mStat = mStat | 'h01;
      default: mStat = mStat & 'hfe;
    endcase
    @(negedge mclk);
    {activityEvt, inactivityEvt, upsetEvt} = '0;
    {queueOverrunEvt, sampleStrobe, queueReadEvt} = '0;
  endtask : ev
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // ============================================================
  // Watchdog, twice the expected run
  initial begin
    #1000000;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end

  // ============================================================
  // Tests
  initial begin
    {activityEvt, inactivityEvt, upsetEvt, queueOverrunEvt} = '0;
    {sampleStrobe, queueReadEvt, int2Req, arst_n} = '0;
    int1Req = 1'b1;
    seqMode = SEQ_DEFAULT;
    sampleIn = '0;
    queueCount = '0;
    watermarkLevel = 10'h080;
    n_fail = 0;
    compares = 0;
    mStat = 'hc0;
    smp = '{0, 0, 0, 0};
    lf = 16'h001c;
    repeat (20) @(posedge mclk);
    @(negedge mclk) arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    rdStat();
    rdChk(OFS_SW_RESET_TRIG, 0);
    rdSmp();
    rdChk(8'h16, 0);
    $display("test reset done");
    host_i.wr(OFS_STATUS_FLAGS, 8'hff);
    mStat = mStat & 'h7f;
    chk({4'h0, int1OeN, int1Out, int2OeN, int2Out}, 8'h04);
    rdStat();
    ev(2);
    rdStat();
    $display("test upset done");
    foreach (modes[m]) begin
      @(negedge mclk) seqMode = modes[m];
      ev(1);
      rdStat();
      ev(0);
      ev(3);
      rdStat();
      rdStat();
    end
    @(negedge mclk) seqMode = SEQ_DEFAULT;
    $display("test modes done");
    qv = '{512, 0, 128, 127, 0, 0};
    foreach (qv[j]) begin
      lf = nextLf(lf);
      @(negedge mclk) queueCount = (j > 3) ? 10'(lf % 513) : 10'(qv[j]);
      repeat (2) @(negedge mclk);
      rdChk(OFS_QCOUNT_LOW, queueCount & 'hff);
      rdChk(OFS_QCOUNT_HIGH, queueCount >> 8);
      rdStat();
    end
    $display("test queue done");
    repeat (3) begin
      foreach (smp[i]) begin
        lf = nextLf(lf);
        smp[i] = lf[11:0];
      end
      ev(4);
      rdSmp();
      rdStat();
      ev(5);
      rdStat();
    end
    $display("test samples done");
    host_i.wr(OFS_SW_RESET_TRIG, 8'h51);
    mStat = mStat & 'h7f;
    rdSmp();
    rdStat();
    host_i.wr(OFS_SW_RESET_TRIG, SW_RESET_CODE);
    chk({7'h0, softResetPulse}, 8'h01);
    chk({6'h0, int1OeN, int2OeN}, 8'h03);
    // Keepers hold the last levels while the mapper asks for new ones
    @(negedge mclk) {int1Req, int2Req} = 2'b01;
    repeat (2) @(negedge mclk);
    chk({4'h0, int1OeN, int1Out, int2OeN, int2Out}, 8'h0e);
    host_i.settle();
    mStat = 'hc0;
    smp = '{0, 0, 0, 0};
    rdSmp();
    rdStat();
    host_i.wr(OFS_STATUS_FLAGS, 8'h00);
    mStat = mStat & 'h7f;
    chk({4'h0, int1OeN, int1Out, int2OeN, int2Out}, 8'h01);
    rdStat();
    $display("test soft reset done");
    final_report();
  end
endmodule : tb_asr_status_sample_regs
`default_nettype wire
